// *** usb_cfg_map.vh ***
// Register offsets, field positions and reset values of the USB configuration slice.
`ifndef USB_CFG_MAP_VH
`define USB_CFG_MAP_VH
`define OFF_SOF_THRESHOLD      4'h0
`define OFF_DESC_BASE_LOW      4'h4
`define OFF_DESC_BASE_MID      4'h8
`define OFF_DESC_BASE_HIGH     4'hc
`define OFF_LINK_CONFIG_ONE    5'h10
`define ADDR_IDX_HI            4
`define ADDR_IDX_LO            2
`define REG_IDX_SOF            3'h0
`define REG_IDX_LOW            3'h1
`define REG_IDX_MID            3'h2
`define REG_IDX_HIGH           3'h3
`define REG_IDX_CFG            3'h4
`define RESET_BYTE             8'h00
`define LOW_FIELD_MASK         8'hfe
`define CFG_FIELD_MASK         8'hd9
`define BIT_EYE_TEST           7
`define BIT_OE_MONITOR         6
`define BIT_STOP_IN_IDLE       4
`define BIT_LOW_SPEED          3
`define BIT_AUTO_SUSPEND       0
`define BASE_ALIGN_ZEROS       9'h000
`define RESP_OKAY              2'h0
`define RESP_SLVERR            2'h2
`define UPPER_ZEROS            24'h000000
`define REG_IDX_NONE           3'h7
`define ADDR_ZERO              5'h00
`define WORD_ZERO              32'h00000000
`define LOW_FIELD_HI           7
`define LOW_FIELD_LO           1
`define SYNC_PINS              4
`define PIN_DRIVE              0
`define PIN_IDLE               1
`define PIN_SLEEP              2
`define PIN_SUSPEND            3
`endif

// *** usb_desc_cfg.v ***
// USB descriptor-table base and first configuration registers behind an AXI4-Lite slave.
// ****************************************
// ****************************************
//
// The placing of the registers and register access over AXI4-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "usb_cfg_map.vh"

module usb_desc_cfg (
	input  wire        clk,
	input  wire        rst_n,
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output wire        s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output wire        s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output wire        s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	input  wire        link_driving,
	input  wire        chip_idle,
	input  wire        chip_sleep,
	input  wire        manual_suspend,
	output reg  [31:0] table_base_address,
	output reg  [7:0]  sof_threshold_value,
	output reg         eye_pattern_test_active,
	output reg         output_enable_monitor,
	output reg         low_speed_device_mode,
	output reg         module_run,
	output reg         module_suspend
);

	// ****************************************
	// Register storage
	// ****************************************
	reg  [7:0]  sof_reg;
	reg  [7:0]  low_reg;
	reg  [7:0]  mid_reg;
	reg  [7:0]  high_reg;
	reg  [7:0]  cfg_reg;
	reg  [4:0]  aw_addr_reg;
	reg         aw_full_reg;
	reg  [7:0]  w_data_reg;
	reg         w_strb_reg;
	reg         w_full_reg;

	// Next values are formed combinationally and loaded at the following edge.
	reg  [7:0]  sof_next;
	reg  [7:0]  low_next;
	reg  [7:0]  mid_next;
	reg  [7:0]  high_next;
	reg  [7:0]  cfg_next;
	reg  [31:0] rdata_next;
	reg  [1:0]  rresp_next;
	reg  [31:0] table_base_next;
	reg         eye_next;
	reg         oe_monitor_next;
	reg         low_speed_next;
	reg         run_next;
	reg         suspend_next;
	wire [3:0]  pin_async;
	wire [3:0]  pin_sync;
	wire        suspend_cause;
	wire        idle_stop;
	genvar      pin_i;

	wire        do_write;
	wire [2:0]  wr_idx;
	wire [2:0]  rd_idx;

	// Decodes a byte address into a register index, or an invalid marker.
	function [2:0] reg_index;
		input [4:0] addr;
		begin
			case (addr)
				{1'b0, `OFF_SOF_THRESHOLD}:  reg_index = `REG_IDX_SOF;
				{1'b0, `OFF_DESC_BASE_LOW}:  reg_index = `REG_IDX_LOW;
				{1'b0, `OFF_DESC_BASE_MID}:  reg_index = `REG_IDX_MID;
				{1'b0, `OFF_DESC_BASE_HIGH}: reg_index = `REG_IDX_HIGH;
				`OFF_LINK_CONFIG_ONE:        reg_index = `REG_IDX_CFG;
				default:                     reg_index = `REG_IDX_NONE;
			endcase
		end
	endfunction

	// Write address and data are taken independently; a held one blocks only its own channel.
	assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
	assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	assign do_write      = aw_full_reg && w_full_reg;
	assign wr_idx        = reg_index(aw_addr_reg);
	assign rd_idx        = reg_index(s_axi_araddr);
	assign pin_async     = {manual_suspend, chip_sleep, chip_idle, link_driving};

	// ****************************************
	// Write channel
	// ****************************************
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_addr_reg  <= `ADDR_ZERO;
			aw_full_reg  <= 1'b0;
			w_data_reg   <= `RESET_BYTE;
			w_strb_reg   <= 1'b0;
			w_full_reg   <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
			sof_reg      <= `RESET_BYTE;
			low_reg      <= `RESET_BYTE;
			mid_reg      <= `RESET_BYTE;
			high_reg     <= `RESET_BYTE;
			cfg_reg      <= `RESET_BYTE;
		end else begin
			// Registers load every edge; the next value holds them when nothing is written.
			sof_reg  <= sof_next;
			low_reg  <= low_next;
			mid_reg  <= mid_next;
			high_reg <= high_next;
			cfg_reg  <= cfg_next;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_reg <= s_axi_awaddr;
				aw_full_reg <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_reg <= s_axi_wdata[7:0];
				w_strb_reg <= s_axi_wstrb[0];
				w_full_reg <= 1'b1;
			end
			if (do_write) begin
				aw_full_reg  <= 1'b0;
				w_full_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_idx == `REG_IDX_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ****************************************
	// Register next values
	// ****************************************
	// Only byte lane 0 carries implemented bits; a write without it stores nothing.
	always @* begin
		sof_next  = sof_reg;
		low_next  = low_reg;
		mid_next  = mid_reg;
		high_next = high_reg;
		cfg_next  = cfg_reg;
		if (do_write && w_strb_reg) begin
			case (wr_idx)
				`REG_IDX_SOF: begin
					sof_next = w_data_reg;
				end
				`REG_IDX_LOW: begin
					low_next = w_data_reg & `LOW_FIELD_MASK;
				end
				`REG_IDX_MID: begin
					mid_next = w_data_reg;
				end
				`REG_IDX_HIGH: begin
					high_next = w_data_reg;
				end
				`REG_IDX_CFG: begin
					cfg_next = w_data_reg & `CFG_FIELD_MASK;
				end
				default: begin
					// Unmapped offsets store nothing.
					cfg_next = cfg_reg;
				end
			endcase
		end
	end

	// ****************************************
	// Read channel
	// ****************************************
	always @* begin
		rdata_next = `WORD_ZERO;
		rresp_next = `RESP_OKAY;
		case (rd_idx)
			`REG_IDX_SOF: begin
				rdata_next = {`UPPER_ZEROS, sof_reg};
			end
			`REG_IDX_LOW: begin
				rdata_next = {`UPPER_ZEROS, low_reg};
			end
			`REG_IDX_MID: begin
				rdata_next = {`UPPER_ZEROS, mid_reg};
			end
			`REG_IDX_HIGH: begin
				rdata_next = {`UPPER_ZEROS, high_reg};
			end
			`REG_IDX_CFG: begin
				rdata_next = {`UPPER_ZEROS, cfg_reg};
			end
			default: begin
				// Unmapped offsets answer with an error and read as zero.
				rresp_next = `RESP_SLVERR;
			end
		endcase
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= `WORD_ZERO;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp  <= rresp_next;
			s_axi_rdata  <= rdata_next;
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

	// ****************************************
	// Pin synchronisers
	// ****************************************
	// Only the second flop feeds logic, so a metastable first stage never reaches a decode.
	generate
		for (pin_i = 0; pin_i < `SYNC_PINS; pin_i = pin_i + 1) begin : g_sync
			reg first_reg;
			reg second_reg;
			always @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					first_reg  <= 1'b0;
					second_reg <= 1'b0;
				end else begin
					first_reg  <= pin_async[pin_i];
					second_reg <= first_reg;
				end
			end
			assign pin_sync[pin_i] = second_reg;
		end
	endgenerate

	// ****************************************
	// Control outputs
	// ****************************************
	// Suspend also stops the module: it gates the 48 MHz clock downstream.
	assign suspend_cause = pin_sync[`PIN_SUSPEND] |
		(cfg_reg[`BIT_AUTO_SUSPEND] & pin_sync[`PIN_SLEEP]);
	assign idle_stop     = cfg_reg[`BIT_STOP_IN_IDLE] & pin_sync[`PIN_IDLE];

	always @* begin
		table_base_next = {high_reg, mid_reg, low_reg[`LOW_FIELD_HI:`LOW_FIELD_LO],
			`BASE_ALIGN_ZEROS};
		eye_next        = cfg_reg[`BIT_EYE_TEST];
		oe_monitor_next = cfg_reg[`BIT_OE_MONITOR] & pin_sync[`PIN_DRIVE];
		low_speed_next  = cfg_reg[`BIT_LOW_SPEED];
		suspend_next    = suspend_cause;
		run_next        = !idle_stop && !suspend_cause;
	end

	// Outputs are registered, so each lags its register or synchronised pin by one clock (a raw pin by three); no glitches reach the PHY.
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			table_base_address      <= `WORD_ZERO;
			sof_threshold_value     <= `RESET_BYTE;
			eye_pattern_test_active <= 1'b0;
			output_enable_monitor   <= 1'b0;
			low_speed_device_mode   <= 1'b0;
			module_run              <= 1'b0;
			module_suspend          <= 1'b0;
		end else begin
			table_base_address      <= table_base_next;
			sof_threshold_value     <= sof_reg;
			eye_pattern_test_active <= eye_next;
			output_enable_monitor   <= oe_monitor_next;
			low_speed_device_mode   <= low_speed_next;
			module_run              <= run_next;
			module_suspend          <= suspend_next;
		end
	end

endmodule // usb_desc_cfg
`default_nettype wire

// *** usb_desc_cfg_chk.sv ***
// Assertion checker for the USB descriptor base and configuration slice.
`timescale 1ns/100ps
`default_nettype none
module usb_desc_cfg_chk (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_rvalid,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [31:0] table_base_address,
	input wire logic eye_pattern_test_active,
	input wire logic low_speed_device_mode,
	input wire logic link_driving,
	input wire logic output_enable_monitor,
	input wire logic chip_idle,
	input wire logic chip_sleep,
	input wire logic manual_suspend,
	input wire logic module_run,
	input wire logic module_suspend
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Settings may only move around a write response, so a change elsewhere is a fault.
	sequence s_wr; s_axi_bvalid || $past(s_axi_bvalid); endsequence
	property p_align; table_base_address[8:0] == 9'h000; endproperty
	a_align: assert property (p_align) else $error("base not aligned");
	property p_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000; endproperty
	a_upper: assert property (p_upper) else $error("upper bits set");
	property p_base; $changed(table_base_address) |-> s_wr; endproperty
	a_base: assert property (p_base) else $error("base moved");
	property p_eye; $changed(eye_pattern_test_active) |-> s_wr; endproperty
	a_eye: assert property (p_eye) else $error("eye test moved");
	property p_lsd; $changed(low_speed_device_mode) |-> s_wr; endproperty
	a_lsd: assert property (p_lsd) else $error("speed mode moved");
	// Two synchroniser stages and one output register give three edges.
	property p_oe; output_enable_monitor |-> $past(link_driving, 3); endproperty
	a_oe: assert property (p_oe) else $error("monitor without drive");
	property p_run; $fell(module_run) && !module_suspend |-> $past(chip_idle, 3); endproperty
	a_run: assert property (p_run) else $error("stopped outside idle");
	property p_sus; $rose(module_suspend) |-> $past(chip_sleep, 3) || $past(manual_suspend, 3);
	endproperty
	a_sus: assert property (p_sus) else $error("suspend without cause");
endmodule // usb_desc_cfg_chk
bind usb_desc_cfg usb_desc_cfg_chk i_chk (.*);
`default_nettype wire

// *** usb_link_partner.sv ***
// Far USB party that drives the data lines in packet bursts.
`timescale 1ns/100ps
`default_nettype none
module usb_link_partner #(parameter int PKT = 8) (
	input  wire logic clk,
	input  wire logic send,
	output wire logic link_driving
);
	int cnt = 0;
	// The lines are driven only within a packet; between packets the far side is silent.
	always @(posedge clk) cnt <= send ? PKT : (cnt > 0 ? cnt - 1 : 0);
	assign link_driving = cnt > 0;
endmodule // usb_link_partner
`default_nettype wire

// *** usb_descriptor_base_and_config_bench.sv ***
// Self-checking bench for the USB descriptor base and configuration slice.
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, s) begin check_count++; if ((s) !== (e)) begin error_cnt++; $display("BAD %s exp %h got %h", n, e, s); end end
module usb_descriptor_base_and_config_bench;
	logic clk = 0, rst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, send = 0;
	logic s_axi_arvalid = 0, s_axi_rready = 0, chip_idle = 0, chip_sleep = 0, manual_suspend = 0;
	logic link_driving, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic eye_pattern_test_active, output_enable_monitor, low_speed_device_mode;
	logic module_run, module_suspend;
	logic [4:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic [31:0] s_axi_wdata = 0, s_axi_rdata, table_base_address;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [7:0] sof_threshold_value;
	logic [7:0] val [5] = '{8'h4a, 8'h5b, 8'ha3, 8'h3c, 8'hff};
	logic [7:0] msk [5] = '{8'hff, 8'hfe, 8'hff, 8'hff, 8'hd9};
	logic [15:0] row [6] = '{16'hffcd, 16'h08c6, 16'h8029, 16'h1080, 16'h0141, 16'h0002};
	logic [3:0] modes;
	int error_cnt = 0, check_count = 0;
	assign modes = {eye_pattern_test_active, low_speed_device_mode, module_run, module_suspend};
	usb_desc_cfg i_dut (.*);
	usb_link_partner i_far (.*);
	initial forever #5 clk = ~clk;
	task automatic stop_test;
		$display("checks %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Handshakes are sampled at the falling edge and acted on at the next rising edge.
	task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		logic ta, tw;
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		s_axi_bready <= 1;
		do begin
			@(negedge clk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			@(posedge clk);
			if (ta) s_axi_awvalid <= 0;
			if (tw) s_axi_wvalid <= 0;
		end while ((s_axi_awvalid && !ta) || (s_axi_wvalid && !tw));
		do @(negedge clk); while (!s_axi_bvalid);
		`CHK("bresp", r, s_axi_bresp)
		@(posedge clk);
		s_axi_bready <= 0;
	endtask
	task automatic rd(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1;
		s_axi_rready <= 1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 0;
		do @(negedge clk); while (!s_axi_rvalid);
		`CHK("rdata", {24'h000000, d}, s_axi_rdata)
		`CHK("rresp", r, s_axi_rresp)
		@(posedge clk);
		s_axi_rready <= 0;
	endtask
	initial begin
		#20000;
		error_cnt++;
		stop_test();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1;
		for (int i = 0; i < 5; i++) rd(5'(i * 4), 8'h00, 2'h0);
		for (int i = 0; i < 5; i++) wr(5'(i * 4), val[i], 2'h0);
		for (int i = 0; i < 5; i++) rd(5'(i * 4), val[i] & msk[i], 2'h0);
		`CHK("base", 32'h3ca35a00, table_base_address)
		`CHK("sof", 8'h4a, sof_threshold_value)
		s_axi_wstrb <= 4'he;
		wr(5'h00, 8'h12, 2'h0);
		s_axi_wstrb <= 4'hf;
		rd(5'h00, 8'h4a, 2'h0);
		wr(5'h14, 8'h55, 2'h2);
		rd(5'h14, 8'h00, 2'h2);
		$display("registers done");
		for (int i = 0; i < 6; i++) begin
			@(posedge clk);
			{chip_idle, chip_sleep, manual_suspend} <= row[i][7:5];
			wr(5'h10, row[i][15:8], 2'h0);
			repeat (6) @(negedge clk);
			`CHK("modes", row[i][3:0], modes)
		end
		wr(5'h10, 8'h40, 2'h0);
		@(posedge clk);
		send <= 1;
		@(posedge clk);
		send <= 0;
		repeat (5) @(negedge clk);
		`CHK("monitor on", 1'b1, output_enable_monitor)
		repeat (10) @(negedge clk);
		`CHK("monitor off", 1'b0, output_enable_monitor)
		$display("modes done");
		stop_test();
	end
endmodule // usb_descriptor_base_and_config_bench
`default_nettype wire
